// >>> pwts_pkg.sv
// Package holding register map, field layout and reset values of the PWM status and compare-A block.
package pwts_pkg;
   localparam int ADDR_W = 8;
   localparam logic [7:0] OFF_TB_STATUS = 8'h00;
   localparam logic [7:0] OFF_COMPARE_A_VALUE = 8'h04;
   localparam logic [7:0] OFF_CMP_CTRL = 8'h08;
   localparam logic [7:0] OFF_TB_CTRL = 8'h0C;
   localparam logic [7:0] OFF_ACT_CFG_A = 8'h10;
   localparam logic [7:0] OFF_ACT_CFG_B = 8'h14;
   localparam logic [7:0] OFF_IRQ_STATUS = 8'h18;
   localparam logic [7:0] OFF_IRQ_MASK = 8'h1C;
   localparam logic [7:0] OFF_COUNTER = 8'h20;
   // Time-base status fields.
   localparam int TBS_DIR = 0;
   localparam int TBS_SYNC = 1;
   localparam int TBS_MAX = 2;
   localparam logic [15:0] TBS_RESET = 16'h0001;
   // Compare control fields.
   localparam int CC_LOAD_LO = 0;
   localparam int CC_SHDW_DIS = 4;
   localparam int CC_SHDW_FULL = 8;
   localparam logic [1:0] LOAD_ZERO = 2'h0;
   localparam logic [1:0] LOAD_PRD = 2'h1;
   localparam logic [1:0] LOAD_ZERO_PRD = 2'h2;
   localparam logic [1:0] LOAD_NONE = 2'h3;
   localparam logic [15:0] COMPARE_A_VALUE_RESET = 16'h0000;
   localparam logic [15:0] COUNTER_MAX = 16'hFFFF;
   // Counter mode codes.
   localparam logic [1:0] MODE_UP = 2'h0;
   localparam logic [1:0] MODE_DOWN = 2'h1;
   localparam logic [1:0] MODE_UPDOWN = 2'h2;
   localparam logic [1:0] MODE_FREEZE = 2'h3;
   // Action codes.
   localparam logic [1:0] ACT_NONE = 2'h0;
   localparam logic [1:0] ACT_CLEAR = 2'h1;
   localparam logic [1:0] ACT_SET = 2'h2;
   localparam logic [1:0] ACT_TOGGLE = 2'h3;
   // Interrupt status bits.
   localparam int IRQ_MAX = 0;
   localparam int IRQ_SYNC = 1;
   localparam int IRQ_COMPARE_A_VALUE = 2;
endpackage

// >>> pwts_action.sv
// Action applier: turns a qualified compare event into an output level change.
module pwts_action
   import pwts_pkg::*;
(
   // Clock and reset.
   input wire logic mclk,
   input wire logic arst_n,
   // Event and configuration.
   input wire logic evt,
   input wire logic [1:0] action,
   // Output.
   output logic pwmOut
);
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         pwmOut <= 1'b0;
      end else if (evt) begin
         case (action)
            ACT_CLEAR: pwmOut <= 1'b0;
            ACT_SET: pwmOut <= 1'b1;
            ACT_TOGGLE: pwmOut <= ~pwmOut;
            default: pwmOut <= pwmOut;
         endcase
      end
   end
endmodule // pwts_action

// >>> pwts_sync.sv
// Two-flop synchroniser with rising-edge pulse for the external sync pin.
module pwts_sync (
   // Clock and reset.
   input wire logic mclk,
   input wire logic arst_n,
   // Pin and pulse.
   input wire logic pinIn,
   output logic risePulse
);
   logic s1Reg;
   logic s2Reg;
   logic s3Reg;
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         s1Reg <= 1'b0;
         s2Reg <= 1'b0;
         s3Reg <= 1'b0;
      end else begin
         s1Reg <= pinIn;
         s2Reg <= s1Reg;
         s3Reg <= s2Reg;
      end
   end
   assign risePulse = s2Reg & ~s3Reg;
endmodule // pwts_sync

// >>> pwts_top.sv
// Time-base status flags, compare-A channel with shadowing, and APB register slave.

// Behaviour
// - The max flag latches when the counter reaches 0xFFFF and clears on a written one.
// - The sync flag latches on each external sync event and clears on a written one.
// - The direction bit reads 1 while counting up and 0 while counting down, read-only.
// - The direction bit reads 1 after reset although the counter is frozen.
// - The active compare-A value is compared with the counter every cycle, raising an event on equality unless the counter mode is freeze.
// - The compare-A event is forwarded to the action stage.
// - Each qualified event does nothing, clears, sets or toggles an output per its configuration.
// - Compare-A shadowing is on after reset.
// - With shadow mode 0, accesses reach the shadow and the active copy loads on the selected event.
// - A readable shadow-full bit shows a pending shadow value.
// - With shadow mode 1, accesses reach the active copy directly.
// - Both copies share one address, selected by the shadow mode bit.
// - The counter mode resets to 11 (freeze); 00 up, 01 down, 10 up-down.
module pwts_top
   import pwts_pkg::*;
#(
   parameter int CNT_W = 16,
   parameter logic [15:0] PERIOD_RESET = 16'hFFFF
) (
   // Clock and reset.
   input wire logic mclk,
   input wire logic arst_n,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // External sync pin.
   input wire logic sync_input,
   // Compare event and PWM outputs.
   output logic cmpAEvent,
   output logic pwm_out_a,
   output logic pwm_out_b,
   // Interrupt.
   output logic irq
);
   logic [CNT_W-1:0] timebase_counter_reg;
   logic countUp_reg;
   logic [1:0] counter_mode_reg;
   logic [15:0] period_reg;
   logic counter_max_flag_reg;
   logic sync_in_flag_reg;
   logic [15:0] cmpAActive_reg;
   logic [15:0] cmpAShadow_reg;
   logic compare_a_shadow_full_reg;
   logic compare_a_shadow_disable_reg;
   logic [1:0] compare_a_load_select_reg;
   logic [1:0] action_config_a_reg;
   logic [1:0] action_config_b_reg;
   logic [2:0] irqStatus_reg;
   logic [2:0] irqMask_reg;
   logic cmpAEvent_reg;
   logic syncPulse;
   logic wrEn;
   logic rdEn;
   logic mapped;
   logic atZero;
   logic atPeriod;
   logic loadEvent;
   logic maxHit;
   logic [15:0] statusView;
   logic [15:0] ctrlView;

   // Decodes whether an address lands on a register.
   function automatic logic isMapped(input logic [ADDR_W-1:0] a);
      case (a)
         OFF_TB_STATUS, OFF_COMPARE_A_VALUE, OFF_CMP_CTRL, OFF_TB_CTRL, OFF_ACT_CFG_A,
         OFF_ACT_CFG_B, OFF_IRQ_STATUS, OFF_IRQ_MASK, OFF_COUNTER: isMapped = 1'b1;
         default: isMapped = 1'b0;
      endcase
   endfunction

   // Zero-wait slave: every access completes in its first access cycle.
   assign pready = 1'b1;
   assign mapped = isMapped(paddr);
   assign pslverr = psel & penable & ~mapped;
   assign wrEn = psel & penable & pwrite & mapped;
   assign rdEn = psel & penable & ~pwrite;

   pwts_sync u_sync (
      .mclk(mclk),
      .arst_n(arst_n),
      .pinIn(sync_input),
      .risePulse(syncPulse)
   );

   // Time-base counter; sync reloads it to zero.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         timebase_counter_reg <= '0;
         countUp_reg <= 1'b1;
      end else if (syncPulse) begin
         timebase_counter_reg <= '0;
      end else begin
         case (counter_mode_reg)
            MODE_UP: begin
               countUp_reg <= 1'b1;
               timebase_counter_reg <= atPeriod ? '0 : timebase_counter_reg + 1'b1;
            end
            MODE_DOWN: begin
               countUp_reg <= 1'b0;
               timebase_counter_reg <= atZero ? CNT_W'(period_reg) :
                  timebase_counter_reg - 1'b1;
            end
            MODE_UPDOWN: begin
               if (countUp_reg && atPeriod) begin
                  countUp_reg <= 1'b0;
                  timebase_counter_reg <= timebase_counter_reg - 1'b1;
               end else if (!countUp_reg && atZero) begin
                  countUp_reg <= 1'b1;
                  timebase_counter_reg <= timebase_counter_reg + 1'b1;
               end else if (countUp_reg) begin
                  timebase_counter_reg <= timebase_counter_reg + 1'b1;
               end else begin
                  timebase_counter_reg <= timebase_counter_reg - 1'b1;
               end
            end
            default: timebase_counter_reg <= timebase_counter_reg;
         endcase
      end
   end

   assign atZero = (timebase_counter_reg == '0);
   assign atPeriod = (timebase_counter_reg == CNT_W'(period_reg));
   assign maxHit = (timebase_counter_reg == CNT_W'(COUNTER_MAX));

   // Control registers written by software.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         counter_mode_reg <= MODE_FREEZE;
         period_reg <= PERIOD_RESET;
         compare_a_shadow_disable_reg <= 1'b0;
         compare_a_load_select_reg <= LOAD_ZERO;
         action_config_a_reg <= ACT_NONE;
         action_config_b_reg <= ACT_NONE;
         irqMask_reg <= 3'h0;
      end else if (wrEn) begin
         case (paddr)
            OFF_TB_CTRL: begin
               counter_mode_reg <= pwdata[1:0];
               period_reg <= pwdata[31:16];
            end
            OFF_CMP_CTRL: begin
               compare_a_load_select_reg <= pwdata[CC_LOAD_LO +: 2];
               compare_a_shadow_disable_reg <= pwdata[CC_SHDW_DIS];
            end
            OFF_ACT_CFG_A: action_config_a_reg <= pwdata[1:0];
            OFF_ACT_CFG_B: action_config_b_reg <= pwdata[1:0];
            OFF_IRQ_MASK: irqMask_reg <= pwdata[2:0];
            default: ;
         endcase
      end
   end

   // Latched max and sync flags.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         counter_max_flag_reg <= 1'b0;
         sync_in_flag_reg <= 1'b0;
      end else begin
         // Max flag set or cleared; set wins.
         if (maxHit) begin
            counter_max_flag_reg <= 1'b1;
         end else if (wrEn && paddr == OFF_TB_STATUS && pwdata[TBS_MAX]) begin
            counter_max_flag_reg <= 1'b0;
         end
         // Sync flag set or cleared; set wins.
         if (syncPulse) begin
            sync_in_flag_reg <= 1'b1;
         end else if (wrEn && paddr == OFF_TB_STATUS && pwdata[TBS_SYNC]) begin
            sync_in_flag_reg <= 1'b0;
         end
      end
   end

   // Load event chosen by the load-select field.
   always_comb begin
      case (compare_a_load_select_reg)
         LOAD_ZERO: loadEvent = atZero;
         LOAD_PRD: loadEvent = atPeriod;
         LOAD_ZERO_PRD: loadEvent = atZero | atPeriod;
         default: loadEvent = 1'b0;
      endcase
   end

   // Compare-A active and shadow copies.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         cmpAActive_reg <= COMPARE_A_VALUE_RESET;
         cmpAShadow_reg <= COMPARE_A_VALUE_RESET;
         compare_a_shadow_full_reg <= 1'b0;
      end else begin
         if (wrEn && paddr == OFF_COMPARE_A_VALUE && compare_a_shadow_disable_reg) begin
            cmpAActive_reg <= pwdata[15:0];
         end else if (!compare_a_shadow_disable_reg && compare_a_shadow_full_reg &&
                      loadEvent) begin
            cmpAActive_reg <= cmpAShadow_reg;
         end
         if (wrEn && paddr == OFF_COMPARE_A_VALUE && !compare_a_shadow_disable_reg) begin
            // Write fills shadow; a new write beats a same-cycle transfer.
            cmpAShadow_reg <= pwdata[15:0];
            compare_a_shadow_full_reg <= 1'b1;
         end else if (compare_a_shadow_disable_reg || loadEvent) begin
            compare_a_shadow_full_reg <= 1'b0;
         end
      end
   end

   // Equality event, registered each cycle the counter matches outside freeze.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         cmpAEvent_reg <= 1'b0;
      end else begin
         cmpAEvent_reg <= (timebase_counter_reg == CNT_W'(cmpAActive_reg)) &&
                          (counter_mode_reg != MODE_FREEZE);
      end
   end
   assign cmpAEvent = cmpAEvent_reg;

   pwts_action u_act_a (
      .mclk(mclk),
      .arst_n(arst_n),
      .evt(cmpAEvent_reg),
      .action(action_config_a_reg),
      .pwmOut(pwm_out_a)
   );

   pwts_action u_act_b (
      .mclk(mclk),
      .arst_n(arst_n),
      .evt(cmpAEvent_reg),
      .action(action_config_b_reg),
      .pwmOut(pwm_out_b)
   );

   // Sticky interrupt status, write one to clear, set wins.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         irqStatus_reg <= 3'h0;
      end else begin
         for (int i = 0; i < 3; i++) begin
            if (i == IRQ_MAX ? maxHit : i == IRQ_SYNC ? syncPulse : cmpAEvent_reg) begin
               irqStatus_reg[i] <= 1'b1;
            end else if (wrEn && paddr == OFF_IRQ_STATUS && pwdata[i]) begin
               irqStatus_reg[i] <= 1'b0;
            end
         end
      end
   end
   assign irq = |(irqStatus_reg & irqMask_reg);

   // Reserved bits read zero; direction bit.
   always_comb begin
      statusView = 16'h0000;
      statusView[TBS_DIR] = countUp_reg;
      statusView[TBS_SYNC] = sync_in_flag_reg;
      statusView[TBS_MAX] = counter_max_flag_reg;
      ctrlView = 16'h0000;
      ctrlView[CC_LOAD_LO +: 2] = compare_a_load_select_reg;
      ctrlView[CC_SHDW_DIS] = compare_a_shadow_disable_reg;
      ctrlView[CC_SHDW_FULL] = compare_a_shadow_full_reg;
   end

   // Registered read data, valid in the setup cycle's following state.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         case (paddr)
            OFF_TB_STATUS: prdata <= {16'h0000, statusView};
            OFF_COMPARE_A_VALUE: prdata <= {16'h0000, compare_a_shadow_disable_reg ?
                                 cmpAActive_reg : cmpAShadow_reg};
            OFF_CMP_CTRL: prdata <= {16'h0000, ctrlView};
            OFF_TB_CTRL: prdata <= {period_reg, 14'h0000, counter_mode_reg};
            OFF_ACT_CFG_A: prdata <= {30'h0000_0000, action_config_a_reg};
            OFF_ACT_CFG_B: prdata <= {30'h0000_0000, action_config_b_reg};
            OFF_IRQ_STATUS: prdata <= {29'h0000_0000, irqStatus_reg};
            OFF_IRQ_MASK: prdata <= {29'h0000_0000, irqMask_reg};
            OFF_COUNTER: prdata <= {16'h0000, 16'(timebase_counter_reg)};
            default: prdata <= 32'h0000_0000;
         endcase
      end else if (!rdEn) begin
         prdata <= prdata;
      end
   end
endmodule // pwts_top

// >>> pwts_top_asserts.sv
// Port checks for the PWM status and compare-A block.
module pwts_top_asserts
   import pwts_pkg::*;
(
   // Clock and reset.
   input wire logic mclk,
   input wire logic arst_n,
   // APB.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Pins.
   input wire logic sync_input,
   input wire logic cmpAEvent,
   input wire logic pwm_out_a,
   input wire logic pwm_out_b
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!arst_n);
   sequence s_read(logic [7:0] a);
      psel && !penable && !pwrite && paddr == a ##1 penable;
   endsequence
   // Writes are kept out of the wait so that a clear cannot hide the event.
   sequence s_syncRise;
      !sync_input ##1 (sync_input && !psel) [*5];
   endsequence
   a_zero_wait: assert property (psel && !penable |=> pready)
      else $error("access phase not ready");
   a_unmapped_err: assert property (psel && penable && paddr > 8'h20 |-> pslverr)
      else $error("unmapped access without error");
   a_mapped_ok: assert property (psel && penable && paddr <= 8'h20 && paddr[1:0] == 2'h0
      |-> !pslverr) else $error("mapped access flagged");
   a_unmapped_zero: assert property ((psel && !penable && !pwrite && paddr > 8'h20 ##1 penable)
      |-> prdata == 32'h0) else $error("unmapped read not zero");
   a_read_stable: assert property (psel && penable && !pwrite |=> $stable(prdata))
      else $error("read data moved in access");
   a_status_rsvd: assert property (s_read(OFF_TB_STATUS) |-> prdata[31:3] == 29'h0)
      else $error("status reserved bits set");
   a_compare_a_value_width: assert property (s_read(OFF_COMPARE_A_VALUE) |-> prdata[31:16] == 16'h0)
      else $error("compare value wider than 16 bits");
   a_pwm_a_hold: assert property (!$past(cmpAEvent) |-> $stable(pwm_out_a))
      else $error("output A moved without event");
   a_pwm_b_hold: assert property (!$past(cmpAEvent) |-> $stable(pwm_out_b))
      else $error("output B moved without event");
   a_sync_flag: assert property (s_syncRise ##1 s_read(OFF_TB_STATUS) |-> prdata[TBS_SYNC])
      else $error("sync event not latched");
endmodule // pwts_top_asserts

bind pwts_top pwts_top_asserts chk_u (.mclk(mclk), .arst_n(arst_n), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .sync_input(sync_input), .cmpAEvent(cmpAEvent),
   .pwm_out_a(pwm_out_a), .pwm_out_b(pwm_out_b));

// >>> pwts_aq_model.sv
// Reference action stage that predicts a PWM output from compare-A events.
module pwts_aq_model
   import pwts_pkg::*;
(
   // Clock and reset.
   input wire logic mclk,
   input wire logic arst_n,
   // Event and configuration.
   input wire logic cmpAEvent,
   input wire logic [1:0] action,
   // Prediction.
   output logic expOut,
   output int evtCount
);
   timeunit 1ns;
   timeprecision 1ps;
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         expOut <= 1'b0;
         evtCount <= 0;
      end else if (cmpAEvent) begin
         evtCount <= evtCount + 1;
         case (action)
            ACT_CLEAR: expOut <= 1'b0;
            ACT_SET: expOut <= 1'b1;
            ACT_TOGGLE: expOut <= !expOut;
            default: expOut <= expOut;
         endcase
      end
   end
endmodule // pwts_aq_model

// >>> pwts_tb.sv
// Self-checking bench for the PWM status and compare-A block.
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_mismatch++; \
   $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module testbench
   import pwts_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 1'b0;
   logic arst_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [ADDR_W-1:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic syncIn = 1'b0;
   logic [1:0] actA = ACT_NONE;
   logic [31:0] prdata, rdData;
   logic pready, pslverr, cmpAEvent, pwmA, pwmB, irq, expA, expB, errBit;
   int n_mismatch = 0;
   int compares = 0;
   int cycles = 0;
   int evtA;
   int k;
   always #4 mclk = ~mclk;
   pwts_top dut_u (.mclk(mclk), .arst_n(arst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .sync_input(syncIn), .cmpAEvent(cmpAEvent), .pwm_out_a(pwmA),
      .pwm_out_b(pwmB), .irq(irq));
   pwts_aq_model mdlA_u (.mclk(mclk), .arst_n(arst_n), .cmpAEvent(cmpAEvent),
      .action(actA), .expOut(expA), .evtCount(evtA));
   pwts_aq_model mdlB_u (.mclk(mclk), .arst_n(arst_n), .cmpAEvent(cmpAEvent),
      .action(ACT_SET), .expOut(expB), .evtCount());
   task automatic final_report();
      if (n_mismatch == 0 && compares > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // The ceiling covers the full climb of the counter to its maximum.
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 80000) begin
         n_mismatch++;
         $display("[ERR] %0t timeout", $time);
         final_report();
      end
   end
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      @(posedge mclk);
      while (pready !== 1'b1) @(posedge mclk);
      rdData = prdata;
      errBit = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      `CHK(rdData, e)
   endtask
   initial begin
      repeat (16) @(posedge mclk);
      arst_n <= 1'b1;
      rd(OFF_TB_STATUS, 32'h0000_0001);
      rd(OFF_CMP_CTRL, 32'h0000_0000);
      rd(OFF_TB_CTRL, 32'hFFFF_0003);
      wr(OFF_TB_STATUS, 32'hFFFF_FFF8);
      rd(OFF_TB_STATUS, 32'h0000_0001);
      syncIn <= 1'b1;
      repeat (4) @(posedge mclk);
      rd(OFF_TB_STATUS, 32'h0000_0003);
      syncIn <= 1'b0;
      `CHK(irq, 1'b0)
      wr(OFF_IRQ_MASK, 32'h0000_0002);
      @(posedge mclk);
      `CHK(irq, 1'b1)
      wr(OFF_IRQ_STATUS, 32'h0000_0002);
      @(posedge mclk);
      `CHK(irq, 1'b0)
      wr(OFF_TB_STATUS, 32'h0000_0002);
      rd(OFF_TB_STATUS, 32'h0000_0001);
      wr(OFF_CMP_CTRL, 32'h0000_0003);
      rd(OFF_CMP_CTRL, 32'h0000_0003);
      wr(OFF_COMPARE_A_VALUE, 32'h0000_0020);
      rd(OFF_CMP_CTRL, 32'h0000_0103);
      rd(OFF_COMPARE_A_VALUE, 32'h0000_0020);
      wr(OFF_CMP_CTRL, 32'h0000_0013);
      rd(OFF_CMP_CTRL, 32'h0000_0013);
      rd(OFF_COMPARE_A_VALUE, 32'h0000_0000);
      wr(OFF_COMPARE_A_VALUE, 32'h0000_0010);
      rd(OFF_COMPARE_A_VALUE, 32'h0000_0010);
      wr(OFF_ACT_CFG_B, 32'h0000_0002);
      wr(OFF_TB_CTRL, 32'h0030_0000);
      rd(OFF_TB_STATUS, 32'h0000_0001);
      for (k = 0; k < 4; k++) begin
         wr(OFF_ACT_CFG_A, 32'(k));
         actA <= k[1:0];
         repeat (60) @(posedge mclk);
         `CHK(pwmA, expA)
      end
      `CHK(evtA >= 4, 1'b1)
      `CHK(pwmB, expB)
      wr(OFF_CMP_CTRL, 32'h0000_0000);
      wr(OFF_COMPARE_A_VALUE, 32'h0000_0005);
      repeat (60) @(posedge mclk);
      rd(OFF_CMP_CTRL, 32'h0000_0000);
      rd(OFF_COMPARE_A_VALUE, 32'h0000_0005);
      wr(OFF_TB_CTRL, 32'h0030_0001);
      rd(OFF_TB_STATUS, 32'h0000_0000);
      wr(OFF_TB_CTRL, 32'hFFFF_0000);
      repeat (65600) @(posedge mclk);
      wr(OFF_TB_STATUS, 32'h0000_0000);
      rd(OFF_TB_STATUS, 32'h0000_0005);
      wr(OFF_TB_STATUS, 32'h0000_0004);
      rd(OFF_TB_STATUS, 32'h0000_0001);
      rd(8'h40, 32'h0000_0000);
      `CHK(errBit, 1'b1)
      final_report();
   end
endmodule // testbench
